// file: src/fdsa_core.sv
// divider core: ratio counter, pulse width, strap address, serial port, snooping
//
// Contract
// RL1: integer mode ratio limited to 32..1048575
// RL2: fractional mode ratio limited to 36..1048571
// RL3: pulse width from control bits 14:12
// RL4: positive rise, negative fall retimed to clock
// RL5: address is msb, mid, lsb strap pins
// RL6: straps sampled at every reset, then held
// RL7: open strap reads one, grounded reads zero
// RL8: snoop companion writes, update own register
// RL9: host may write shared setting once
// RL10: snooping off when companion equals own address
// RL11: own write only when frame address matches
`timescale 1ns/1ns
`default_nettype none
module fdsa_core (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic spiSck,
   input wire logic spiSenN,
   input wire logic spiSdi,
   output logic spiSdo,
   input wire logic addr_strap_lsb,
   input wire logic addr_strap_mid,
   input wire logic addr_strap_msb,
   output logic div_out_pos,
   output logic div_out_neg
);
   import fdsa_pkg::*;

   // pin synchronisers; stage one is read by stage two only
   logic [2:0] pinS1_q;
   logic [2:0] pinS2_q;
   logic sckS3_q;
   logic senS3_q;
   logic [2:0] strapS1_q;
   logic [2:0] strapS2_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         // idle levels: enable high, clock low, so no false edge after reset
         pinS1_q <= 3'h4;
         pinS2_q <= 3'h4;
         sckS3_q <= 1'b0;
         senS3_q <= 1'b1;
         strapS1_q <= 3'h7;
         strapS2_q <= 3'h7;
      end else begin
         pinS1_q <= {spiSenN, spiSck, spiSdi};
         pinS2_q <= pinS1_q;
         sckS3_q <= pinS2_q[1];
         senS3_q <= pinS2_q[2];
         // pull-ups make an open pin arrive as one
         strapS1_q <= {addr_strap_msb, addr_strap_mid, addr_strap_lsb}; // see RL5 see RL7
         strapS2_q <= strapS1_q;
      end
   end

   logic sdiS;
   logic sckRise;
   logic frameStart;
   logic frameEnd;
   assign sdiS = pinS2_q[0];
   assign sckRise = pinS2_q[1] & ~sckS3_q & ~pinS2_q[2];
   assign frameStart = ~pinS2_q[2] & senS3_q;
   assign frameEnd = pinS2_q[2] & ~senS3_q;

   // strap capture, restarted by hard or soft reset
   logic softRst;
   logic [1:0] settle_q;
   logic capDone_q;
   logic [2:0] ownAddr_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         settle_q <= 2'h0;
         capDone_q <= 1'b0;
         ownAddr_q <= 3'h7;
      end else if (softRst) begin
         settle_q <= 2'h0;
         capDone_q <= 1'b0;
      end else if (!capDone_q) begin
         if (settle_q == STRAP_SETTLE) begin
            capDone_q <= 1'b1;
            ownAddr_q <= strapS2_q; // see RL6
         end else begin
            settle_q <= settle_q + 2'h1;
         end
      end
   end

   // receive shifter
   logic [31:0] rx_q;
   logic [5:0] bitCnt_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_q <= 32'h00000000;
         bitCnt_q <= 6'h00;
      end else if (frameStart) begin
         bitCnt_q <= 6'h00;
      end else if (sckRise) begin
         rx_q <= {rx_q[30:0], sdiS};
         if (bitCnt_q != 6'h3f) begin
            bitCnt_q <= bitCnt_q + 6'h01;
         end
      end
   end

   logic [23:0] rxData;
   logic [4:0] rxReg;
   logic [2:0] rxChip;
   logic commit;
   logic snoopEn;
   logic ownHit;
   logic snoopHit;
   logic [2:0] compAddr_q;
   assign rxData = rx_q[FRM_DATA_LSB +: DATA_BITS];
   assign rxReg = rx_q[FRM_REG_LSB +: REG_BITS];
   assign rxChip = rx_q[FRM_CHIP_LSB +: CHIP_BITS];
   // short or long frames are dropped
   assign commit = frameEnd && (bitCnt_q == FRAME_LEN) && capDone_q;
   assign snoopEn = (compAddr_q != ownAddr_q); // see RL10
   assign ownHit = commit && (rxChip == ownAddr_q); // see RL11
   assign snoopHit = commit && snoopEn && (rxChip == compAddr_q)
      && (rxReg == COMP_REFDIV_OFS); // see RL8
   assign softRst = ownHit && (rxReg == REG_CTRL_OFS) && rxData[CTRL_SOFTRST_BIT];

   // register file
   logic [4:0] rdAddr_q;
   logic [2:0] duty_q;
   logic frac_q;
   logic [19:0] ratio_q;
   logic [23:0] refDiv_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdAddr_q <= RDADDR_RST;
         duty_q <= DUTY_RST;
         frac_q <= FRAC_RST;
         ratio_q <= RATIO_RST;
         refDiv_q <= REFDIV_RST;
         compAddr_q <= COMP_RST;
      end else if (softRst) begin
         rdAddr_q <= RDADDR_RST;
         duty_q <= DUTY_RST;
         frac_q <= FRAC_RST;
         ratio_q <= RATIO_RST;
         refDiv_q <= REFDIV_RST;
         compAddr_q <= COMP_RST;
      end else begin
         if (ownHit && rxReg == REG_CTRL_OFS) begin
            rdAddr_q <= rxData[CTRL_RDADDR_LSB +: REG_BITS];
            duty_q <= rxData[CTRL_DUTY_LSB +: DUTY_BITS]; // see RL3
            frac_q <= rxData[CTRL_FRAC_BIT];
         end
         if (ownHit && rxReg == REG_RATIO_OFS) begin
            ratio_q <= rxData[RATIO_BITS-1:0];
         end
         // one companion frame sets both chips
         if ((ownHit && rxReg == REG_REFDIV_OFS) || snoopHit) begin
            refDiv_q <= rxData; // see RL8 see RL9
         end
         if (ownHit && rxReg == REG_COMP_OFS) begin
            compAddr_q <= rxData[CHIP_BITS-1:0];
         end
      end
   end

   // readback word chosen by the read address field
   logic [23:0] rdWord;
   always_comb begin
      rdWord = 24'h000000;
      unique case (rdAddr_q)
         REG_CTRL_OFS: rdWord = {8'h00, frac_q, duty_q, 9'h000, ownAddr_q};
         REG_REFDIV_OFS: rdWord = refDiv_q;
         REG_RATIO_OFS: rdWord = {4'h0, ratio_q};
         REG_COMP_OFS: rdWord = {21'h0, compAddr_q};
         default: rdWord = 24'h000000;
      endcase
   end

   logic [23:0] txSh_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txSh_q <= 24'h000000;
         spiSdo <= 1'b0;
      end else if (frameStart) begin
         txSh_q <= rdWord;
         spiSdo <= rdWord[23];
      end else if (sckRise) begin
         txSh_q <= {txSh_q[22:0], 1'b0};
         spiSdo <= txSh_q[22];
      end
   end

   // ratio counter; a new ratio takes effect at the next output period
   logic [19:0] effRatio;
   logic [19:0] divCnt_q;
   logic [2:0] width_q;
   logic wrap;
   assign effRatio = clampRatio(frac_q, ratio_q); // see RL1 see RL2
   assign wrap = (divCnt_q == 20'h00000);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         divCnt_q <= 20'h00000;
         width_q <= 3'h0;
         div_out_pos <= 1'b0;
         div_out_neg <= 1'b1;
      end else begin
         if (wrap) begin
            divCnt_q <= effRatio - 20'h00001;
         end else begin
            divCnt_q <= divCnt_q - 20'h00001;
         end
         // width in clock periods is field plus one, always below the ratio
         if (wrap) begin
            width_q <= duty_q; // see RL3
            div_out_pos <= 1'b1; // see RL4
            div_out_neg <= 1'b0; // see RL4
         end else if (width_q != 3'h0) begin
            width_q <= width_q - 3'h1;
         end else begin
            div_out_pos <= 1'b0;
            div_out_neg <= 1'b1;
         end
      end
   end

   // helper: high pulse length and the duty field it began with
   logic [3:0] highLen_q;
   logic [2:0] wrapDuty_q;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         highLen_q <= 4'h0;
         wrapDuty_q <= 3'h0;
      end else begin
         if (wrap) begin
            wrapDuty_q <= duty_q;
         end
         if (div_out_pos) begin
            highLen_q <= highLen_q + 4'h1;
         end else begin
            highLen_q <= 4'h0;
         end
      end
   end

   AST_INT_RANGE: assert property (@(posedge clk_sys) disable iff (rst) // see RL1
      wrap && !frac_q |=> (divCnt_q >= INT_RATIO_MIN - 20'h00001
         && divCnt_q <= INT_RATIO_MAX - 20'h00001))
      else $error("integer ratio out of range");
   AST_FRAC_RANGE: assert property (@(posedge clk_sys) disable iff (rst) // see RL2
      wrap && frac_q |=> (divCnt_q >= FRAC_RATIO_MIN - 20'h00001
         && divCnt_q <= FRAC_RATIO_MAX - 20'h00001))
      else $error("fractional ratio out of range");
   AST_PULSE_WIDTH: assert property (@(posedge clk_sys) disable iff (rst) // see RL3
      $fell(div_out_pos) |-> highLen_q == {1'b0, wrapDuty_q} + 4'h1)
      else $error("pulse width differs from duty field");
   AST_EDGE_PAIR: assert property (@(posedge clk_sys) disable iff (rst) // see RL4
      $rose(div_out_pos) |-> $fell(div_out_neg) ##1 (div_out_neg == !div_out_pos))
      else $error("divider output edges not aligned");
   AST_STRAP_ORDER: assert property (@(posedge clk_sys) disable iff (rst) // see RL5
      $rose(capDone_q) |-> ownAddr_q == $past({addr_strap_msb, addr_strap_mid, addr_strap_lsb}, 3))
      else $error("strap address taken in wrong order");
   AST_ADDR_HELD: assert property (@(posedge clk_sys) disable iff (rst) // see RL6
      capDone_q && !softRst |=> $stable(ownAddr_q))
      else $error("captured address changed without reset");
   AST_SNOOP_UPDATE: assert property (@(posedge clk_sys) disable iff (rst) // see RL8
      snoopHit |=> refDiv_q == $past(rxData))
      else $error("companion write not followed");
   AST_SNOOP_OFF: assert property (@(posedge clk_sys) disable iff (rst) // see RL10
      commit && compAddr_q == ownAddr_q && rxChip != ownAddr_q |=> $stable(refDiv_q))
      else $error("snoop active with own address");
   AST_FOREIGN_IGNORED: assert property (@(posedge clk_sys) disable iff (rst) // see RL11
      commit && rxChip != ownAddr_q |=> $stable(ratio_q) && $stable(compAddr_q))
      else $error("foreign frame changed own register");

   COV_OWN_WRITE: cover property (@(posedge clk_sys) disable iff (rst) ownHit);
   COV_SNOOP: cover property (@(posedge clk_sys) disable iff (rst) snoopHit);
   COV_SOFT_RESET: cover property (@(posedge clk_sys) disable iff (rst) softRst ##[1:8] capDone_q);
   COV_FRAC_PULSE: cover property (@(posedge clk_sys) disable iff (rst) frac_q && $rose(div_out_pos));
endmodule : fdsa_core
`default_nettype wire

// file: src/fdsa_pkg.sv
// constants and helpers for the divider core with strap-addressed serial port
package fdsa_pkg;
   localparam int FRAME_BITS = 32;
   localparam int DATA_BITS = 24;
   localparam int REG_BITS = 5;
   localparam int CHIP_BITS = 3;
   localparam int RATIO_BITS = 20;
   localparam int DUTY_BITS = 3;
   // frame layout, first bit on the wire is bit 31
   localparam int FRM_DATA_LSB = 8;
   localparam int FRM_REG_LSB = 3;
   localparam int FRM_CHIP_LSB = 0;
   localparam logic [5:0] FRAME_LEN = 6'h20;
   // register offsets
   localparam logic [4:0] REG_CTRL_OFS = 5'h00;
   localparam logic [4:0] REG_REFDIV_OFS = 5'h02;
   localparam logic [4:0] REG_RATIO_OFS = 5'h05;
   localparam logic [4:0] REG_COMP_OFS = 5'h09;
   // offset of the companion's reference divider register
   localparam logic [4:0] COMP_REFDIV_OFS = 5'h02;
   // control register fields
   localparam int CTRL_RDADDR_LSB = 0;
   localparam int CTRL_SOFTRST_BIT = 5;
   localparam int CTRL_DUTY_LSB = 12;
   localparam int CTRL_FRAC_BIT = 15;
   // reset values
   localparam logic [4:0] RDADDR_RST = 5'h00;
   localparam logic [2:0] DUTY_RST = 3'h3;
   localparam logic FRAC_RST = 1'b0;
   localparam logic [19:0] RATIO_RST = 20'h00020;
   localparam logic [23:0] REFDIV_RST = 24'h000001;
   localparam logic [2:0] COMP_RST = 3'h7;
   // ratio limits per mode
   localparam logic [19:0] INT_RATIO_MIN = 20'h00020;
   localparam logic [19:0] INT_RATIO_MAX = 20'hfffff;
   localparam logic [19:0] FRAC_RATIO_MIN = 20'h00024;
   localparam logic [19:0] FRAC_RATIO_MAX = 20'hffffb;
   // cycles after reset release before the straps are taken
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   function automatic logic [19:0] clampRatio(input logic frac, input logic [19:0] raw);
      logic [19:0] lo;
      logic [19:0] hi;
      lo = frac ? FRAC_RATIO_MIN : INT_RATIO_MIN;
      hi = frac ? FRAC_RATIO_MAX : INT_RATIO_MAX;
      if (raw < lo) begin
         return lo;
      end else if (raw > hi) begin
         return hi;
      end
      return raw;
   endfunction : clampRatio
endpackage : fdsa_pkg

// file: test/fdsa_host.sv
// behavioural serial host that frames commands and collects readback
`timescale 1ns/1ns
`default_nettype none
module fdsa_host (
   input wire logic clk_sys,
   input wire logic spiSdo,
   output var logic spiSck,
   output var logic spiSenN,
   output var logic spiSdi
);
   initial begin
      spiSck = 1'b0;
      spiSenN = 1'b1;
      spiSdi = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   // six clocks per level, above the three the synchronisers need
   task automatic xfer(input logic [31:0] frm, output logic [23:0] rbk);
      rbk = 24'h0;
      spiSenN = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         spiSdi = frm[i];
         tick(6);
         if (i >= 8) rbk[i-8] = spiSdo;
         spiSck = 1'b1;
         tick(6);
         spiSck = 1'b0;
      end
      spiSenN = 1'b1;
      // released line must not keep showing the last bit
      spiSdi = ~frm[0];
      tick(8);
   endtask : xfer
endmodule : fdsa_host
`default_nettype wire

// file: test/fdsa_core_tb.sv
// self-checking bench for the divider core and its serial port
`timescale 1ns/1ns
`default_nettype none
module fdsa_core_tb;
   import fdsa_pkg::*;
   logic clk_sys, rst, spiSck, spiSenN, spiSdi, spiSdo;
   logic strapL, strapM, strapH, divPos, divNeg;
   logic [23:0] rbk;
   logic [2:0] own;
   logic [2:0] dutyV;
   logic fracV;
   int bad_count = 0;
   int total_checks = 0;
   fdsa_core u_fdsa_core (.clk_sys(clk_sys), .rst(rst), .spiSck(spiSck), .spiSenN(spiSenN),
      .spiSdi(spiSdi), .spiSdo(spiSdo), .addr_strap_lsb(strapL), .addr_strap_mid(strapM),
      .addr_strap_msb(strapH), .div_out_pos(divPos), .div_out_neg(divNeg));
   fdsa_host u_fdsa_host (.clk_sys(clk_sys), .spiSdo(spiSdo), .spiSck(spiSck),
      .spiSenN(spiSenN), .spiSdi(spiSdi));
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   function automatic logic [23:0] ctl(input logic [4:0] ra, input logic sr);
      return {8'h0, fracV, dutyV, 6'h0, sr, ra};
   endfunction : ctl
   task automatic wr(input logic [4:0] r, input logic [23:0] d, input logic [2:0] c);
      u_fdsa_host.xfer({d, r, c}, rbk);
   endtask : wr
   // readback word is latched at frame start, so a second frame fetches it
   task automatic rd(input string what, input logic [4:0] r, input logic [23:0] exp);
      wr(REG_CTRL_OFS, ctl(r, 1'b0), own);
      wr(5'h01, 24'h0, own);
      chk(what, exp, rbk);
   endtask : rd
   // skips two rises so a freshly written ratio has been loaded
   task automatic meas(input string what, input int per, input int hi);
      int p;
      int h;
      int nb;
      logic was;
      repeat (2) @(posedge divPos);
      #1;
      p = 0;
      h = 0;
      nb = 0;
      was = 1'b1;
      while (!(divPos === 1'b1 && was === 1'b0) && p < 200) begin
         if (divPos === 1'b1) h++;
         if (divNeg !== ~divPos) nb++;
         was = divPos;
         @(posedge clk_sys);
         #1;
         p++;
      end
      chk({what, " period"}, 24'(per), 24'(p));
      chk({what, " width"}, 24'(hi), 24'(h));
      chk({what, " inverse"}, 24'h0, 24'(nb));
   endtask : meas
   initial begin
      rst = 1'b1;
      {strapH, strapM, strapL} = 3'h5;
      own = 3'h5;
      dutyV = DUTY_RST;
      fracV = FRAC_RST;
      repeat (3) @(posedge clk_sys);
      #1;
      chk("pos in reset", 24'h0, {23'h0, divPos});
      chk("neg in reset", 24'h1, {23'h0, divNeg});
      rst = 1'b0;
      u_fdsa_host.tick(6);
      rd("ctrl", REG_CTRL_OFS, {8'h0, FRAC_RST, DUTY_RST, 9'h0, 3'h5});
      rd("ratio", REG_RATIO_OFS, {4'h0, RATIO_RST});
      rd("refdiv", REG_REFDIV_OFS, REFDIV_RST);
      rd("comp", REG_COMP_OFS, {21'h0, COMP_RST});
      meas("default", 32, 4);
      $display("test reset values ends");
      dutyV = 3'h5;
      wr(REG_CTRL_OFS, ctl(5'h0, 1'b0), own);
      wr(REG_RATIO_OFS, 24'h000028, own);
      meas("ratio 40", 40, 6);
      wr(REG_RATIO_OFS, 24'h00001f, own);
      meas("below int min", 32, 6);
      fracV = 1'b1;
      wr(REG_CTRL_OFS, ctl(5'h0, 1'b0), own);
      wr(REG_RATIO_OFS, 24'h000023, own);
      meas("below frac min", 36, 6);
      wr(REG_RATIO_OFS, 24'h000025, own);
      meas("frac 37", 37, 6);
      wr(REG_RATIO_OFS, 24'h000030, 3'h4);
      meas("foreign chip", 37, 6);
      $display("test divider ends");
      wr(REG_COMP_OFS, 24'h000003, own);
      wr(REG_REFDIV_OFS, 24'h000055, 3'h3);
      rd("snooped refdiv", REG_REFDIV_OFS, 24'h000055);
      wr(REG_RATIO_OFS, 24'h000040, 3'h3);
      meas("ratio not shared", 37, 6);
      wr(REG_COMP_OFS, {21'h0, own}, own);
      wr(REG_REFDIV_OFS, 24'h000077, 3'h3);
      rd("snoop off", REG_REFDIV_OFS, 24'h000055);
      $display("test companion ends");
      // straps move without a reset: captured address must not follow
      {strapH, strapM, strapL} = 3'h3;
      rd("addr held", REG_CTRL_OFS, {8'h0, fracV, dutyV, 9'h0, 3'h5});
      wr(REG_CTRL_OFS, ctl(5'h0, 1'b1), own);
      own = 3'h3;
      dutyV = DUTY_RST;
      fracV = FRAC_RST;
      u_fdsa_host.tick(10);
      rd("soft resample", REG_CTRL_OFS, {8'h0, FRAC_RST, DUTY_RST, 9'h0, 3'h3});
      rd("soft refdiv", REG_REFDIV_OFS, REFDIV_RST);
      {strapH, strapM, strapL} = 3'h6;
      rst = 1'b1;
      u_fdsa_host.tick(2);
      rst = 1'b0;
      own = 3'h6;
      u_fdsa_host.tick(6);
      rd("hard resample", REG_CTRL_OFS, {8'h0, FRAC_RST, DUTY_RST, 9'h0, 3'h6});
      $display("test strap capture ends");
      wrap_up();
   end
   // about thirty frames of some 392 clocks each, with ample margin
   initial begin
      repeat (40000) @(posedge clk_sys);
      bad_count++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      wrap_up();
   end
endmodule : fdsa_core_tb
`default_nettype wire
